// ---- rtl/byte_fifo.sv ----
`timescale 1ns/10ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk, // Clock.
   input wire logic resetn, // Asynchronous reset, active low.
   input wire logic in_valid, // Writer offers a word.
   output logic in_ready, // Room for a word.
   input wire logic [WIDTH-1:0] in_data, // Word written.
   output logic out_valid, // A word is available.
   input wire logic out_ready, // Reader takes the word.
   output logic [WIDTH-1:0] out_data // Oldest word.
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [PW:0] cnt_reg, cnt_next;
   logic push, pop;

   always_comb begin
      in_ready = (cnt_reg != DEPTH_C);
      out_valid = (cnt_reg != '0);
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      wr_next = push ? wr_reg + 1'b1 : wr_reg;
      rd_next = pop ? rd_reg + 1'b1 : rd_reg;
      cnt_next = cnt_reg;
      if (push && !pop) begin
         cnt_next = cnt_reg + 1'b1;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - 1'b1;
      end
      out_data = mem_reg[rd_reg];
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
      end
   end

   // Storage needs no reset; entries are only read once written.
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data;
      end
   end
endmodule // byte_fifo

// ---- rtl/pin_sync.sv ----
`timescale 1ns/10ps
module pin_sync #(
   parameter int WIDTH = 2
) (
   input wire logic clk, // Sampling clock.
   input wire logic resetn, // Asynchronous reset, active low.
   input wire logic [WIDTH-1:0] pin_in, // Raw pins from outside the domain.
   output logic [WIDTH-1:0] pin_out // Filtered level, changes when stages two and three agree.
);
   logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, stable_reg;
   logic [WIDTH-1:0] stable_next;

   always_comb begin
      stable_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & stable_reg);
   end

   // Pins idle high, so reset to all ones to avoid a fake edge at release.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1_reg <= '1;
         s2_reg <= '1;
         s3_reg <= '1;
         stable_reg <= '1;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         stable_reg <= stable_next;
      end
   end

   assign pin_out = stable_reg;
endmodule // pin_sync

// ---- rtl/two_wire_slave_tx.sv ----
`timescale 1ns/10ps
module two_wire_slave_tx (
   input wire logic SYS_CLK, // System clock, 200 MHz.
   input wire logic RESETN, // Asynchronous reset, active low.
   input wire logic SCL_IN, // Bus clock line level.
   output logic SCL_OUT, // Bus clock drive value, always low.
   output logic SCL_OE, // High while pulling SCL low.
   input wire logic SDA_IN, // Bus data line level.
   output logic SDA_OUT, // Bus data drive value, always low.
   output logic SDA_OE, // High while pulling SDA low.
   input wire logic [7:0] OWN_ADDRESS, // Own slave address, bit 0 general call enable.
   input wire logic CTRL_WR, // Control write strobe, one cycle.
   input wire logic WR_ACK_ENABLE, // Written ack enable.
   input wire logic WR_START_REQUEST, // Written start request.
   input wire logic WR_STOP_REQUEST, // Written stop request.
   input wire logic WR_DONE_CLEAR, // Write one clears the job done flag.
   output logic ACK_ENABLE, // Ack enable bit.
   output logic START_REQUEST, // Start request bit.
   output logic STOP_REQUEST, // Stop request bit.
   output logic JOB_DONE_FLAG, // Done flag, software response expected.
   output logic [7:0] STATUS, // Bus status value.
   output logic [7:0] SHIFT_DATA, // Shift data register contents.
   input wire logic [7:0] TX_DATA, // Byte to send.
   input wire logic TX_VALID, // Byte offered.
   output logic TX_READY, // Buffer has room.
   input wire logic DEEP_SLEEP, // Part is in a sleep mode other than idle.
   output logic WAKE_REQUEST, // Address match seen while asleep.
   input wire logic ARB_LOST, // Master side lost arbitration, one-cycle pulse.
   output logic BUS_BUSY, // Bus owned between START and STOP.
   output logic START_GRANT // Queued start may go, bus is free.
);
   logic [1:0] pins;
   logic scl, sda, scl_d_reg, sda_d_reg;
   logic scl_rise, scl_fall, start_det, stop_det;

   two_wire_pkg::slave_state_t state_reg, state_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] status_reg, status_next;
   logic done_reg, done_next;
   logic ack_en_reg, ack_en_next;
   logic start_req_reg, start_req_next;
   logic stop_req_reg, stop_req_next;
   logic last_reg, last_next;
   logic nack_reg, nack_next;
   logic arb_reg, arb_next;
   logic wake_reg, wake_next;
   logic busy_reg, busy_next;
   logic sda_low_reg, sda_low_next;
   logic scl_low_reg, scl_low_next;
   logic done_clr, illegal_pos;
   logic fifo_valid, fifo_pop;
   logic [7:0] fifo_data;

   function automatic logic addr_match(input logic [6:0] addr, input logic [7:0] own);
      addr_match = (addr == own[7:1]) ||
                   ((addr == two_wire_pkg::GENERAL_CALL_ADDRESS) && own[two_wire_pkg::GCE_BIT]);
   endfunction

   pin_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk(SYS_CLK),
      .resetn(RESETN),
      .pin_in({SCL_IN, SDA_IN}),
      .pin_out(pins)
   );

   byte_fifo #(
      .WIDTH(two_wire_pkg::DATA_W),
      .DEPTH(two_wire_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk(SYS_CLK),
      .resetn(RESETN),
      .in_valid(TX_VALID),
      .in_ready(TX_READY),
      .in_data(TX_DATA),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   assign scl = pins[1];
   assign sda = pins[0];

   always_comb begin
      scl_rise = scl && !scl_d_reg;
      scl_fall = !scl && scl_d_reg;
      start_det = scl && scl_d_reg && sda_d_reg && !sda;
      stop_det = scl && scl_d_reg && !sda_d_reg && sda;
   end

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl;
         sda_d_reg <= sda;
      end
   end

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      status_next = status_reg;
      done_next = done_reg;
      ack_en_next = ack_en_reg;
      start_req_next = start_req_reg;
      stop_req_next = stop_req_reg;
      last_next = last_reg;
      nack_next = nack_reg;
      arb_next = arb_reg;
      wake_next = wake_reg;
      busy_next = busy_reg;
      sda_low_next = sda_low_reg;
      fifo_pop = 1'b0;

      if (CTRL_WR) begin
         ack_en_next = WR_ACK_ENABLE;
         start_req_next = WR_START_REQUEST;
         stop_req_next = WR_STOP_REQUEST;
      end
      done_clr = CTRL_WR && WR_DONE_CLEAR && done_reg;
      if (done_clr) begin
         done_next = 1'b0;
         wake_next = 1'b0;
      end
      // A repeated START leaves busy set, so ownership is never handed back mid-sequence.
      if (start_det) begin
         busy_next = 1'b1;
      end else if (stop_det) begin
         busy_next = 1'b0;
      end

      case (state_reg)
         two_wire_pkg::SL_IDLE: begin
            // Not addressed: clocks are ignored, only a START is looked for.
            if (start_det) begin
               state_next = two_wire_pkg::SL_ADDR;
               cnt_next = 4'h0;
            end
         end
         two_wire_pkg::SL_ADDR: begin
            // The address is shifted into the data register, which overwrites its byte.
            if (scl_rise) begin
               shift_next = {shift_reg[6:0], sda};
               cnt_next = cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == two_wire_pkg::ADDR_BITS_DONE) begin
               if (ack_en_reg && shift_reg[0] && addr_match(shift_reg[7:1], OWN_ADDRESS)) begin
                  state_next = two_wire_pkg::SL_ADDR_ACK;
                  sda_low_next = 1'b1;
               end else begin
                  state_next = two_wire_pkg::SL_IDLE;
                  arb_next = 1'b0;
               end
            end
         end
         two_wire_pkg::SL_ADDR_ACK: begin
            if (scl_rise) begin
               cnt_next = cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == two_wire_pkg::ACK_BIT_DONE) begin
               sda_low_next = 1'b0;
               done_next = 1'b1;
               // Wake is raised after the ack clock, so the SCL hold cannot stall that clock.
               wake_next = DEEP_SLEEP;
               status_next = arb_reg ? two_wire_pkg::ST_ARB_LOST_READ
                                     : two_wire_pkg::ST_OWN_READ;
               arb_next = 1'b0;
               state_next = two_wire_pkg::SL_TX_WAIT;
            end
         end
         two_wire_pkg::SL_TX_WAIT: begin
            // An empty buffer keeps the state waiting, but SCL is released once the done flag is clear.
            if (!done_reg && !wake_reg && fifo_valid) begin
               fifo_pop = 1'b1;
               shift_next = fifo_data;
               last_next = !ack_en_reg;
               cnt_next = 4'h0;
               sda_low_next = !fifo_data[7];
               state_next = two_wire_pkg::SL_TX_BIT;
            end
         end
         two_wire_pkg::SL_TX_BIT: begin
            if (scl_rise) begin
               cnt_next = cnt_reg + 4'h1;
            end else if (scl_fall) begin
               if (cnt_reg == two_wire_pkg::TX_BITS_DONE) begin
                  sda_low_next = 1'b0;
                  state_next = two_wire_pkg::SL_TX_ACK;
               end else begin
                  shift_next = {shift_reg[6:0], 1'b1};
                  sda_low_next = !shift_reg[6];
               end
            end
         end
         two_wire_pkg::SL_TX_ACK: begin
            if (scl_rise) begin
               nack_next = sda;
               cnt_next = cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == two_wire_pkg::ACK_BIT_DONE) begin
               done_next = 1'b1;
               if (nack_reg) begin
                  status_next = two_wire_pkg::ST_DATA_NACK;
                  state_next = two_wire_pkg::SL_DONE_WAIT;
               end else if (last_reg) begin
                  status_next = two_wire_pkg::ST_LAST_ACK;
                  state_next = two_wire_pkg::SL_DONE_WAIT;
               end else begin
                  status_next = two_wire_pkg::ST_DATA_ACK;
                  state_next = two_wire_pkg::SL_TX_WAIT;
               end
            end
         end
         two_wire_pkg::SL_DONE_WAIT: begin
            // Recognition later follows ack enable; a queued start waits in START_GRANT.
            if (done_clr) begin
               state_next = two_wire_pkg::SL_IDLE;
            end
         end
         two_wire_pkg::SL_ERROR: begin
            if (done_clr && stop_req_next) begin
               state_next = two_wire_pkg::SL_IDLE;
               stop_req_next = 1'b0;
               sda_low_next = 1'b0;
            end
         end
         default: begin
            state_next = two_wire_pkg::SL_IDLE;
         end
      endcase

      // Set after the state logic, so a new loss wins over a clear in the same cycle.
      if (ARB_LOST) begin
         arb_next = 1'b1;
      end

      illegal_pos = ((state_reg == two_wire_pkg::SL_ADDR) && (cnt_reg != 4'h0)) ||
                    (state_reg == two_wire_pkg::SL_ADDR_ACK) ||
                    (state_reg == two_wire_pkg::SL_TX_BIT) ||
                    (state_reg == two_wire_pkg::SL_TX_ACK);
      if ((start_det || stop_det) && illegal_pos) begin
         state_next = two_wire_pkg::SL_ERROR;
         status_next = two_wire_pkg::ST_BUS_ERROR;
         done_next = 1'b1;
         sda_low_next = 1'b0;
      end else if (start_det && state_reg != two_wire_pkg::SL_ERROR) begin
         state_next = two_wire_pkg::SL_ADDR;
         cnt_next = 4'h0;
         sda_low_next = 1'b0;
      end else if (stop_det && state_reg != two_wire_pkg::SL_ERROR) begin
         state_next = two_wire_pkg::SL_IDLE;
         sda_low_next = 1'b0;
      end

      // The bus error state releases SCL so that a stuck bus can be recovered.
      scl_low_next = (done_next || wake_next) &&
                     (state_next != two_wire_pkg::SL_ERROR);
   end

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_reg <= two_wire_pkg::SL_IDLE;
         cnt_reg <= 4'h0;
         shift_reg <= two_wire_pkg::SHIFT_RESET;
         status_reg <= two_wire_pkg::ST_NO_INFO;
         done_reg <= 1'b0;
         ack_en_reg <= 1'b0;
         start_req_reg <= 1'b0;
         stop_req_reg <= 1'b0;
         last_reg <= 1'b0;
         nack_reg <= 1'b0;
         arb_reg <= 1'b0;
         wake_reg <= 1'b0;
         busy_reg <= 1'b0;
         sda_low_reg <= 1'b0;
         scl_low_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         status_reg <= status_next;
         done_reg <= done_next;
         ack_en_reg <= ack_en_next;
         start_req_reg <= start_req_next;
         stop_req_reg <= stop_req_next;
         last_reg <= last_next;
         nack_reg <= nack_next;
         arb_reg <= arb_next;
         wake_reg <= wake_next;
         busy_reg <= busy_next;
         sda_low_reg <= sda_low_next;
         scl_low_reg <= scl_low_next;
      end
   end

   assign SCL_OUT = 1'b0;
   assign SDA_OUT = 1'b0;
   assign SCL_OE = scl_low_reg;
   assign SDA_OE = sda_low_reg;
   assign ACK_ENABLE = ack_en_reg;
   assign START_REQUEST = start_req_reg;
   assign STOP_REQUEST = stop_req_reg;
   assign JOB_DONE_FLAG = done_reg;
   assign SHIFT_DATA = shift_reg;
   assign WAKE_REQUEST = wake_reg;
   assign BUS_BUSY = busy_reg;
   assign START_GRANT = start_req_reg && !busy_reg;
   // Low three bits are the masked prescaler field.
   assign STATUS = done_reg ? {status_reg[7:two_wire_pkg::STATUS_LSB],
                               two_wire_pkg::PRESCALE_MASKED}
                            : two_wire_pkg::ST_NO_INFO;
endmodule // two_wire_slave_tx

// ---- shared/two_wire_pkg.sv ----
// Notes on behaviour
// - Outside idle sleep, address match still works, clocked by bus SCL when acks enabled.
// - After a wake-up match, SCL stays low until software clears the done flag.
// - On wake-up the data register need not hold the last bus byte.
// - Status 0xA8 after own address with read acked; ack_enable picks last byte.
// - Status 0xB0 after lost arbitration then own address with read acked.
// - Status 0xB8 after a data byte was sent and acknowledged by master.
// - Status 0xC0 after a data byte got NACK; then not-addressed slave mode.
// - Status 0xC8 when the last byte still gets ACK; then not-addressed mode.
// - Leaving 0xC0/0xC8: ack_enable governs recognition; start request waits for free bus.
// - Status reads 0xF8 whenever the done flag is clear.
// - START or STOP inside a byte or ack bit gives status 0x00 and done.
// - Recovery enters not-addressed mode, clears only stop request, releases both lines.
// - A repeated START keeps bus ownership while the direction changes.
// - Status code sits in bits 7 to 3; the low bits read zero.
// - Own address in upper seven bits; bit 0 enables general call address.
// - While done is set, SCL low period is stretched except in the bus error state; clearing restarts work.
// - After the last byte, further master clocking is ignored so master reads ones.
package two_wire_pkg;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam logic [3:0] ADDR_BITS_DONE = 4'h8;
   localparam logic [3:0] ACK_BIT_DONE = 4'h9;
   localparam logic [3:0] TX_BITS_DONE = 4'h8;
   localparam int STATUS_LSB = 3;
   localparam int GCE_BIT = 0;
   localparam logic [6:0] GENERAL_CALL_ADDRESS = 7'h00;
   localparam logic [2:0] PRESCALE_MASKED = 3'h0;
   localparam logic [7:0] ST_OWN_READ = 8'ha8;
   localparam logic [7:0] ST_ARB_LOST_READ = 8'hb0;
   localparam logic [7:0] ST_DATA_ACK = 8'hb8;
   localparam logic [7:0] ST_DATA_NACK = 8'hc0;
   localparam logic [7:0] ST_LAST_ACK = 8'hc8;
   localparam logic [7:0] ST_NO_INFO = 8'hf8;
   localparam logic [7:0] ST_BUS_ERROR = 8'h00;
   localparam logic [1:0] PIN_IDLE = 2'h3;
   localparam logic [7:0] SHIFT_RESET = 8'hff;

   typedef enum logic [2:0] {
      SL_IDLE,
      SL_ADDR,
      SL_ADDR_ACK,
      SL_TX_WAIT,
      SL_TX_BIT,
      SL_TX_ACK,
      SL_DONE_WAIT,
      SL_ERROR
   } slave_state_t;
endpackage

// ---- verif/master_rx_model.sv ----
`timescale 1ns/10ps
module master_rx_model (
   input wire logic scl, // Clock wire level.
   input wire logic sda, // Data wire level.
   output logic scl_low, // High while pulling the clock low.
   output logic sda_low // High while pulling the data low.
);
   int stall_count = 0;
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // SDA is released first, then SCL, so the same task also makes a repeated START.
   task automatic start();
      sda_low = 1'b0;
      #16;
      scl_low = 1'b0;
      #32;
      sda_low = 1'b1;
      #32;
      scl_low = 1'b1;
      #16;
   endtask
   task automatic stop();
      sda_low = 1'b1;
      #16;
      scl_low = 1'b0;
      #32;
      sda_low = 1'b0;
      #32;
   endtask
   // The slave may stretch the low phase, so the high phase is timed from the wire.
   task automatic clk_bit(input logic b, output logic r);
      int n;
      sda_low = !b;
      #16;
      scl_low = 1'b0;
      n = 0;
      while (scl !== 1'b1 && n < 4000) begin
         #5;
         n++;
      end
      // A clock held low past the bound is counted by the bench as a mismatch.
      if (n >= 4000) stall_count++;
      #16;
      r = sda;
      #16;
      scl_low = 1'b1;
      #16;
   endtask
   task automatic xfer(input logic [7:0] d, input logic a_in, output logic [7:0] q,
      output logic a);
      for (int i = 7; i >= 0; i--) begin
         clk_bit(d[i], q[i]);
      end
      clk_bit(a_in, a);
   endtask
endmodule // master_rx_model

// ---- verif/two_wire_slave_tx_asserts.sv ----
`timescale 1ns/10ps
module two_wire_slave_tx_asserts (
   input wire logic SYS_CLK, // System clock.
   input wire logic RESETN, // Reset, active low.
   input wire logic SCL_OE, // Clock line pull.
   input wire logic SDA_OE, // Data line pull.
   input wire logic CTRL_WR, // Control write strobe.
   input wire logic WR_ACK_ENABLE, // Written ack enable.
   input wire logic WR_START_REQUEST, // Written start request.
   input wire logic WR_STOP_REQUEST, // Written stop request.
   input wire logic WR_DONE_CLEAR, // Done clear.
   input wire logic ACK_ENABLE, // Ack enable bit.
   input wire logic START_REQUEST, // Start request bit.
   input wire logic STOP_REQUEST, // Stop request bit.
   input wire logic JOB_DONE_FLAG, // Done flag.
   input wire logic [7:0] STATUS, // Status value.
   input wire logic WAKE_REQUEST, // Wake request.
   input wire logic BUS_BUSY, // Bus owned.
   input wire logic START_GRANT // Start may go.
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);
   sequence err_s;
      JOB_DONE_FLAG && STATUS == 8'h00;
   endsequence
   sequence recover_s;
      err_s ##0 (CTRL_WR && WR_STOP_REQUEST && WR_DONE_CLEAR);
   endsequence
   sequence tail_clear_s;
      JOB_DONE_FLAG && STATUS inside {8'hc0, 8'hc8} && CTRL_WR && WR_DONE_CLEAR;
   endsequence
   no_info_a: assert property (!JOB_DONE_FLAG |-> STATUS == 8'hf8)
      else $error("status is not f8 while done is clear");
   low_bits_a: assert property (JOB_DONE_FLAG |-> STATUS[2:0] == 3'h0)
      else $error("status low bits not zero");
   done_code_a: assert property ($rose(JOB_DONE_FLAG) |->
      STATUS inside {8'ha8, 8'hb0, 8'hb8, 8'hc0, 8'hc8, 8'h00}) else $error("bad status code");
   stretch_hold_a: assert property ($past(JOB_DONE_FLAG) && JOB_DONE_FLAG && STATUS != 8'h00 |-> SCL_OE)
      else $error("clock not stretched while done");
   wake_hold_a: assert property ($past(WAKE_REQUEST) && WAKE_REQUEST |-> SCL_OE)
      else $error("clock not held during wake");
   err_free_a: assert property (err_s ##1 JOB_DONE_FLAG |-> !SCL_OE && !SDA_OE)
      else $error("lines held after bus error");
   err_recover_a: assert property (recover_s |=> !STOP_REQUEST && !JOB_DONE_FLAG && !SCL_OE)
      else $error("bus error recovery wrong");
   tail_idle_a: assert property (tail_clear_s |=> !SDA_OE [*4])
      else $error("data line driven after last byte");
   ctrl_load_a: assert property (CTRL_WR |=> ACK_ENABLE == $past(WR_ACK_ENABLE) &&
      START_REQUEST == $past(WR_START_REQUEST)) else $error("control bits not loaded");
   start_grant_a: assert property (START_GRANT == (START_REQUEST && !BUS_BUSY))
      else $error("start grant wrong");
endmodule // two_wire_slave_tx_asserts
bind two_wire_slave_tx two_wire_slave_tx_asserts chk (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
   .SCL_OE(SCL_OE), .SDA_OE(SDA_OE), .CTRL_WR(CTRL_WR), .WR_ACK_ENABLE(WR_ACK_ENABLE),
   .WR_START_REQUEST(WR_START_REQUEST), .WR_STOP_REQUEST(WR_STOP_REQUEST),
   .WR_DONE_CLEAR(WR_DONE_CLEAR), .ACK_ENABLE(ACK_ENABLE), .START_REQUEST(START_REQUEST),
   .STOP_REQUEST(STOP_REQUEST), .JOB_DONE_FLAG(JOB_DONE_FLAG), .STATUS(STATUS),
   .WAKE_REQUEST(WAKE_REQUEST), .BUS_BUSY(BUS_BUSY), .START_GRANT(START_GRANT));

// ---- verif/two_wire_slave_tx_tb.sv ----
`timescale 1ns/10ps
module two_wire_slave_tx_tb;
   logic SYS_CLK, RESETN, CTRL_WR, WR_ACK_ENABLE, WR_START_REQUEST, WR_STOP_REQUEST;
   logic WR_DONE_CLEAR, TX_VALID, DEEP_SLEEP, ARB_LOST, SCL_OUT, SCL_OE, SDA_OUT, SDA_OE;
   logic ACK_ENABLE, START_REQUEST, STOP_REQUEST, JOB_DONE_FLAG, TX_READY, WAKE_REQUEST;
   logic BUS_BUSY, START_GRANT, scl_low, sda_low, a;
   logic [7:0] TX_DATA, STATUS, SHIFT_DATA, q;
   wire scl_w;
   wire sda_w;
   int fail_count = 0;
   int checks_done = 0;
   // Both lines are open drain with pull-ups: any party pulling low wins.
   assign scl_w = !(SCL_OE || scl_low);
   assign sda_w = !(SDA_OE || sda_low);
   two_wire_slave_tx uut (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .SCL_IN(scl_w), .SCL_OUT(SCL_OUT),
      .SCL_OE(SCL_OE), .SDA_IN(sda_w), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .OWN_ADDRESS(8'ha5),
      .CTRL_WR(CTRL_WR), .WR_ACK_ENABLE(WR_ACK_ENABLE), .WR_START_REQUEST(WR_START_REQUEST),
      .WR_STOP_REQUEST(WR_STOP_REQUEST), .WR_DONE_CLEAR(WR_DONE_CLEAR), .ACK_ENABLE(ACK_ENABLE),
      .START_REQUEST(START_REQUEST), .STOP_REQUEST(STOP_REQUEST), .JOB_DONE_FLAG(JOB_DONE_FLAG),
      .STATUS(STATUS), .SHIFT_DATA(SHIFT_DATA), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
      .TX_READY(TX_READY), .DEEP_SLEEP(DEEP_SLEEP), .WAKE_REQUEST(WAKE_REQUEST),
      .ARB_LOST(ARB_LOST), .BUS_BUSY(BUS_BUSY), .START_GRANT(START_GRANT));
   master_rx_model far_end (.scl(scl_w), .sda(sda_w), .scl_low(scl_low), .sda_low(sda_low));
   always #2.5 SYS_CLK = ~SYS_CLK;
   task automatic finish_test();
      fail_count += far_end.stall_count;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // A zero selects the done flag, a one selects the start grant.
   task automatic wait_hi(input logic sel);
      int n;
      n = 0;
      while ((sel ? START_GRANT : JOB_DONE_FLAG) !== 1'b1 && n < 2000) begin
         @(posedge SYS_CLK);
         n++;
      end
      #1;
      if (n >= 2000) begin
         fail_count++;
         $display("CHECK FAILED bounded wait expected 1 seen 0");
         finish_test();
      end
   endtask
   task automatic ctrl(input logic ae, input logic st, input logic sp, input logic clr);
      @(posedge SYS_CLK);
      CTRL_WR <= 1'b1;
      WR_ACK_ENABLE <= ae;
      WR_START_REQUEST <= st;
      WR_STOP_REQUEST <= sp;
      WR_DONE_CLEAR <= clr;
      @(posedge SYS_CLK);
      CTRL_WR <= 1'b0;
      WR_DONE_CLEAR <= 1'b0;
      #1;
   endtask
   task automatic push(input logic [7:0] d);
      @(posedge SYS_CLK);
      TX_VALID <= 1'b1;
      TX_DATA <= d;
      @(posedge SYS_CLK);
      TX_VALID <= 1'b0;
      #1;
   endtask
   task automatic t_reset();
      chk("status", STATUS, 8'hf8);
      chk("shift data", SHIFT_DATA, 8'hff);
      chk("drive levels", {6'h0, SCL_OUT, SDA_OUT}, 8'h00);
      chk("ready", 8'(TX_READY), 8'h01);
      chk("control", {5'h0, ACK_ENABLE, START_REQUEST, STOP_REQUEST}, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_read();
      ctrl(1'b1, 1'b0, 1'b0, 1'b0);
      push(8'h3c);
      push(8'hc3);
      far_end.start();
      far_end.xfer(8'ha4, 1'b1, q, a);
      chk("write ack", 8'(a), 8'h01);
      far_end.start();
      chk("busy kept", 8'(BUS_BUSY), 8'h01);
      far_end.xfer(8'ha5, 1'b1, q, a);
      chk("address ack", 8'(a), 8'h00);
      wait_hi(1'b0);
      chk("status", STATUS, 8'ha8);
      chk("clock hold", 8'(SCL_OE), 8'h01);
      ctrl(1'b1, 1'b0, 1'b0, 1'b1);
      far_end.xfer(8'hff, 1'b0, q, a);
      chk("first byte", q, 8'h3c);
      wait_hi(1'b0);
      chk("status", STATUS, 8'hb8);
      ctrl(1'b0, 1'b0, 1'b0, 1'b0);
      ctrl(1'b0, 1'b0, 1'b0, 1'b1);
      far_end.xfer(8'hff, 1'b1, q, a);
      chk("last byte", q, 8'hc3);
      wait_hi(1'b0);
      chk("status", STATUS, 8'hc0);
      ctrl(1'b1, 1'b1, 1'b0, 1'b1);
      chk("grant busy", 8'(START_GRANT), 8'h00);
      far_end.xfer(8'hff, 1'b0, q, a);
      chk("ignored read", q, 8'hff);
      far_end.stop();
      wait_hi(1'b1);
      chk("grant free", 8'(START_GRANT), 8'h01);
      ctrl(1'b1, 1'b0, 1'b0, 1'b0);
      $display("test read done");
   endtask
   task automatic t_arb();
      @(posedge SYS_CLK);
      ARB_LOST <= 1'b1;
      DEEP_SLEEP <= 1'b1;
      @(posedge SYS_CLK);
      ARB_LOST <= 1'b0;
      push(8'h96);
      far_end.start();
      far_end.xfer(8'ha5, 1'b1, q, a);
      chk("address ack", 8'(a), 8'h00);
      wait_hi(1'b0);
      chk("status", STATUS, 8'hb0);
      chk("wake", 8'(WAKE_REQUEST), 8'h01);
      chk("wake hold", 8'(SCL_OE), 8'h01);
      ctrl(1'b0, 1'b0, 1'b0, 1'b0);
      ctrl(1'b0, 1'b0, 1'b0, 1'b1);
      @(posedge SYS_CLK);
      DEEP_SLEEP <= 1'b0;
      far_end.xfer(8'hff, 1'b0, q, a);
      chk("last byte", q, 8'h96);
      wait_hi(1'b0);
      chk("status", STATUS, 8'hc8);
      ctrl(1'b0, 1'b0, 1'b0, 1'b1);
      far_end.stop();
      far_end.start();
      far_end.xfer(8'ha5, 1'b1, q, a);
      chk("no recognition", 8'(a), 8'h01);
      far_end.stop();
      $display("test arbitration done");
   endtask
   task automatic t_buserr();
      ctrl(1'b1, 1'b0, 1'b0, 1'b0);
      far_end.start();
      repeat (3) far_end.clk_bit(1'b1, a);
      far_end.stop();
      wait_hi(1'b0);
      chk("status", STATUS, 8'h00);
      chk("clock free", 8'(SCL_OE), 8'h00);
      ctrl(1'b1, 1'b0, 1'b1, 1'b1);
      chk("stop bit", 8'(STOP_REQUEST), 8'h00);
      chk("ack bit", 8'(ACK_ENABLE), 8'h01);
      chk("status", STATUS, 8'hf8);
      $display("test bus error done");
   endtask
   task automatic t_fill();
      @(posedge SYS_CLK);
      TX_VALID <= 1'b1;
      TX_DATA <= 8'h77;
      repeat (17) @(posedge SYS_CLK);
      TX_VALID <= 1'b0;
      #1;
      chk("full", 8'(TX_READY), 8'h00);
      far_end.start();
      far_end.xfer(8'h01, 1'b1, q, a);
      chk("general call", 8'(a), 8'h00);
      $display("test fill done");
   endtask
   initial begin
      SYS_CLK = 1'b0;
      RESETN = 1'b0;
      {CTRL_WR, WR_ACK_ENABLE, WR_START_REQUEST, WR_STOP_REQUEST, WR_DONE_CLEAR} = 5'h0;
      {TX_VALID, DEEP_SLEEP, ARB_LOST} = 3'h0;
      TX_DATA = 8'h00;
      repeat (4) @(posedge SYS_CLK);
      RESETN <= 1'b1;
      repeat (4) @(posedge SYS_CLK);
      #1;
      t_reset();
      t_read();
      t_arb();
      t_buserr();
      t_fill();
      finish_test();
   end
endmodule // two_wire_slave_tx_tb
